// ### hdl/flash_program_control.sv
// APB control and status registers for the flash programming controller
//
// Contract
// RQ1: Start sets only when armed and freshly unlocked
// RQ2: Start launches selected op, hardware clears it
// RQ3: Arm opens start, closes op select
// RQ4: Failure flag set by hardware on bad sequence
// RQ5: Low-voltage flag set by hardware on undervoltage
// RQ6: Flags clear only by launching null op
// RQ7: Control bits reset only by power-on reset
// RQ8: Op select is four bits, resets zero
// RQ9: Reserved bit eleven reads zero
// RQ10: Unimplemented bits read zero, ignore writes
// RQ11: Two key writes unlock the next write; the code opens only the next access, so a read in between closes the window
// RQ12: Busy operation freezes op select and arm
`timescale 1ns/1ps
`include "flash_prog_defs.svh"

module flash_program_control
  import flash_prog_pkg::*;
#(
  parameter int OP_CYCLES = `OP_CYCLES,
  parameter logic [31:0] KEY_FIRST = `KEY_FIRST_DEF, // Arbitrary value
  parameter logic [31:0] KEY_SECOND = `KEY_SECOND_DEF // Arbitrary value
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash array condition pins
  input wire logic low_volt_pin,
  input wire logic array_fault_pin,
  // Status outputs
  output logic op_busy,
  output logic irq
);

  ctrl_s ctrl_r, ctrl_nxt;
  unlock_e unl_r, unl_nxt;
  logic [`IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic pready_r;
  logic irq_r;
  logic busy_q_r;
  logic [1:0] lv_sync_r, fault_sync_r;
  logic seq_busy;
  result_s seq_res;

  // Decoded access: only the access phase acts, once
  logic acc, wr, rd;
  logic hit_ctrl, hit_key, hit_stat, hit_mask, hit_fstat, hit_any;
  logic all_lanes;
  logic [31:0] ctrl_view;
  logic [31:0] rd_mux;
  logic start_req, launch;
  logic op_wr_ok, arm_wr_ok;
  logic [`IRQ_W-1:0] ev;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] off);
    return a[11:2] == off[11:2];
  endfunction

  assign acc = psel & penable & ~pready_r;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign hit_ctrl = addr_is(paddr, `OFF_CTRL);
  assign hit_key = addr_is(paddr, `OFF_KEY);
  assign hit_stat = addr_is(paddr, `OFF_IRQ_STAT);
  assign hit_mask = addr_is(paddr, `OFF_IRQ_MASK);
  assign hit_fstat = addr_is(paddr, `OFF_FLASH_STAT);
  assign hit_any = hit_ctrl | hit_key | hit_stat | hit_mask | hit_fstat;
  // Key writes must carry the whole word, partial writes void unlock
  assign all_lanes = (pstrb == 4'hF);

  // Pins come from the array's analog side, so synchronise them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lv_sync_r <= 2'b00;
      fault_sync_r <= 2'b00;
    end else begin
      lv_sync_r <= {lv_sync_r[0], low_volt_pin};
      fault_sync_r <= {fault_sync_r[0], array_fault_pin};
    end
  end

  // Register view; bit 11 and unused ranges are constant zero
  always_comb begin
    ctrl_view = 32'h0000_0000; // [RQ9] [RQ10]
    ctrl_view[`BIT_START] = ctrl_r.start;
    ctrl_view[`BIT_ARM] = ctrl_r.arm;
    ctrl_view[`BIT_FAIL] = ctrl_r.fail;
    ctrl_view[`BIT_UV] = ctrl_r.uv;
    ctrl_view[`OP_LSB +: `OP_W] = ctrl_r.op;
  end

  assign rd_mux = hit_ctrl ? ctrl_view :
                  hit_stat ? {29'h0, irq_stat_r} :
                  hit_mask ? {29'h0, irq_mask_r} :
                  hit_fstat ? {30'h0, seq_busy, lv_sync_r[1]} :
                  32'h0000_0000;

  // Unlock window: two correct keys back to back, then one access
  always_comb begin
    unl_nxt = unl_r;
    if (acc) begin
      case (unl_r)
        unl_idle: unl_nxt = (wr && hit_key && all_lanes &&
                             pwdata == KEY_FIRST) ? unl_half : unl_idle;
        unl_half: unl_nxt = (wr && hit_key && all_lanes &&
                             pwdata == KEY_SECOND) ? unl_open : unl_idle;
        unl_open: unl_nxt = unl_idle; // [RQ11]
        default: unl_nxt = unl_idle;
      endcase
    end
  end

  // Start accepted only when armed and the window is open
  assign start_req = wr && hit_ctrl && pstrb[1] && pwdata[`BIT_START];
  assign launch = start_req && ctrl_r.arm && (unl_r == unl_open) &&
                  !ctrl_r.start; // [RQ1] [RQ3] [RQ11]
  assign op_wr_ok = wr && hit_ctrl && pstrb[0] && !ctrl_r.arm &&
                    !ctrl_r.start; // [RQ3] [RQ12]
  assign arm_wr_ok = wr && hit_ctrl && pstrb[1] && !ctrl_r.start; // [RQ12]

  // Control register next value
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (arm_wr_ok) begin
      ctrl_nxt.arm = pwdata[`BIT_ARM];
    end
    if (op_wr_ok) begin
      ctrl_nxt.op = pwdata[`OP_LSB +: `OP_W]; // [RQ8]
    end
    // Software zero on start is ignored; only hardware clears it
    if (launch) begin
      ctrl_nxt.start = 1'b1; // [RQ1] [RQ2]
    end else if (seq_res.done) begin
      ctrl_nxt.start = 1'b0; // [RQ2]
    end
    // Null launch clears flags; a hardware result later sets them again
    if (launch && ctrl_r.op == `OP_NULL) begin
      ctrl_nxt.fail = 1'b0; // [RQ6]
      ctrl_nxt.uv = 1'b0; // [RQ6]
    end
    if (seq_res.done && seq_res.fail) begin
      ctrl_nxt.fail = 1'b1; // [RQ4]
    end
    if (seq_res.done && seq_res.uv) begin
      ctrl_nxt.uv = 1'b1; // [RQ5]
    end
  end

  // Interrupt events; hardware set beats a same-cycle software clear
  assign ev[`IRQ_DONE] = seq_res.done;
  assign ev[`IRQ_FAIL] = seq_res.done & seq_res.fail;
  assign ev[`IRQ_UV] = seq_res.done & seq_res.uv;
  assign irq_stat_nxt = (irq_stat_r &
                         ~((wr && hit_stat) ? pwdata[`IRQ_W-1:0] : '0))
                        | ev;

  assign prdata_nxt = rd ? rd_mux : prdata_r;
  assign pslverr_nxt = acc & ~hit_any;

  // Control bits live on power-on reset only, not the bus reset
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ctrl_r <= ctrl_s'($bits(ctrl_s)'(`CTRL_RESET)); // [RQ7]
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Bus side state follows the ordinary reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_r <= unl_idle;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
      irq_r <= 1'b0;
      busy_q_r <= 1'b0;
    end else begin
      unl_r <= unl_nxt;
      irq_stat_r <= irq_stat_nxt;
      if (wr && hit_mask) begin
        irq_mask_r <= pwdata[`IRQ_W-1:0];
      end
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pready_r <= acc;
      irq_r <= |(irq_stat_nxt & irq_mask_r);
      busy_q_r <= seq_busy;
    end
  end

  // Timed operation engine
  flash_op_sequencer #(
    .OP_CYCLES(OP_CYCLES)
  ) u_seq (
    .pclk(pclk),
    .presetn(por_n),
    .launch(launch),
    .op(ctrl_r.op),
    .low_volt(lv_sync_r[1]),
    .array_fault(fault_sync_r[1]),
    .busy(seq_busy),
    .result(seq_res)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign op_busy = busy_q_r;

endmodule // flash_program_control

// ### include/flash_prog_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FLASH_PROG_DEFS_SVH
`define FLASH_PROG_DEFS_SVH

`define OFF_CTRL 12'h000
`define OFF_KEY 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00C
`define OFF_FLASH_STAT 12'h010

`define BIT_START 15
`define BIT_ARM 14
`define BIT_FAIL 13
`define BIT_UV 12
`define OP_LSB 0
`define OP_W 4

`define OP_NULL 4'h0
`define CTRL_RESET 32'h0000_0000
`define KEY_FIRST_DEF 32'hAA99_6655
`define KEY_SECOND_DEF 32'h5566_99AA

`define OP_TIME_NS 800
`define CLK_PERIOD_NS 8
`define OP_CYCLES (`OP_TIME_NS / `CLK_PERIOD_NS)

`define IRQ_DONE 0
`define IRQ_FAIL 1
`define IRQ_UV 2
`define IRQ_W 3

`endif

// ### include/flash_prog_pkg.sv
// Types shared by the flash program control block
package flash_prog_pkg;

  typedef enum logic [1:0] {
    unl_idle,
    unl_half,
    unl_open
  } unlock_e;

  typedef enum logic [1:0] {
    seq_idle,
    seq_busy,
    seq_done
  } seq_e;

  typedef struct packed {
    logic start;
    logic arm;
    logic fail;
    logic uv;
    logic [3:0] op;
  } ctrl_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic uv;
  } result_s;

endpackage

// ### hdl/flash_op_sequencer.sv
// Timed flash operation sequencer with failure and low-voltage capture
`timescale 1ns/1ps
`include "flash_prog_defs.svh"

module flash_op_sequencer
  import flash_prog_pkg::*;
#(
  parameter int OP_CYCLES = `OP_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Launch request
  input wire logic launch,
  input wire logic [3:0] op,
  // Array condition, already synchronised
  input wire logic low_volt,
  input wire logic array_fault,
  // Result
  output logic busy,
  output result_s result
);

  localparam int CW = $clog2(OP_CYCLES + 1);

  seq_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic uv_seen_r, uv_seen_nxt;
  logic fault_seen_r, fault_seen_nxt;
  logic is_null;

  // The null operation only clears flags, so it finishes at once
  assign is_null = (op == `OP_NULL);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    uv_seen_nxt = uv_seen_r | (state_r == seq_busy && low_volt);
    fault_seen_nxt = fault_seen_r | (state_r == seq_busy && array_fault);
    case (state_r)
      seq_idle: begin
        if (launch) begin
          uv_seen_nxt = 1'b0;
          fault_seen_nxt = 1'b0;
          cnt_nxt = is_null ? '0 : CW'(OP_CYCLES - 1);
          state_nxt = is_null ? seq_done : seq_busy;
        end
      end
      seq_busy: begin
        if (cnt_r == '0) begin
          state_nxt = seq_done;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      seq_done: state_nxt = seq_idle;
      default: state_nxt = seq_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= seq_idle;
      cnt_r <= '0;
      uv_seen_r <= 1'b0;
      fault_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      uv_seen_r <= uv_seen_nxt;
      fault_seen_r <= fault_seen_nxt;
    end
  end

  // Undervoltage also fails the sequence, since the cells may be corrupt
  assign busy = (state_r != seq_idle);
  assign result.done = (state_r == seq_done);
  assign result.uv = uv_seen_r;
  assign result.fail = fault_seen_r | uv_seen_r;

endmodule // flash_op_sequencer

// ### tb/flash_program_control_props.sv
// Port-level assertions for the flash program control block
`timescale 1ns/1ps
`include "flash_prog_defs.svh"
module flash_program_control_props
  import flash_prog_pkg::*;
#(
  parameter int OP_CYCLES = 100
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and status
  input wire logic low_volt_pin,
  input wire logic array_fault_pin,
  input wire logic op_busy,
  input wire logic irq
);
  // Generous bound: busy lags start by a cycle and a null op is shorter
  localparam int OPM = OP_CYCLES + 4;
  logic [2:0] win_r;
  wire wr_go = psel && penable && pwrite && paddr == `OFF_CTRL && pwdata[15];
  wire rd_ctrl = pready && !pwrite && paddr == `OFF_CTRL;
  // Short window after a start write in which a launch may appear
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) win_r <= 3'h0;
    else win_r <= wr_go ? 3'h6 : win_r - {2'h0, win_r != 3'h0};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && $past(penable))
    else $error("pready outside access");
  a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > `OFF_FLASH_STAT)) else $error("pslverr wrong");
  a_ctrl_unimpl: assert property (rd_ctrl |-> prdata[31:16] == 16'h0 &&
    prdata[10:4] == 7'h0) else $error("unimplemented bits not zero");
  a_resv_zero: assert property (rd_ctrl |-> !prdata[11])
    else $error("reserved bit not zero");
  a_start_cause: assert property ($rose(op_busy) |-> win_r != 3'h0)
    else $error("operation without start write");
  a_op_finish: assert property ($rose(op_busy) |-> ##[1:OPM] !op_busy)
    else $error("operation did not finish");
  cover property ($rose(op_busy));
  cover property (pready && pslverr);
  cover property ($rose(irq));
endmodule // flash_program_control_props

bind flash_program_control flash_program_control_props #(
  .OP_CYCLES(OP_CYCLES)
) u_props (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_volt_pin(low_volt_pin), .array_fault_pin(array_fault_pin),
  .op_busy(op_busy), .irq(irq));

// ### tb/test_flash_program_control.sv
// Self-checking bench for the flash program control block
`timescale 1ns/1ps
`include "flash_prog_defs.svh"
module test_flash_program_control
  import flash_prog_pkg::*;
;
  localparam logic [11:0] CT = `OFF_CTRL;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, d;
  logic [3:0] pstrb = 4'h0, op;
  logic pready, pslverr, op_busy, irq, err;
  logic low_volt_pin = 0, array_fault_pin = 0;
  int num_errors = 0, comparisons = 0, seed = 32'haf0ec14a;
  always #4 pclk = ~pclk;
  // Short operations keep the run brief
  flash_program_control #(.OP_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_volt_pin(low_volt_pin),
    .array_fault_pin(array_fault_pin), .op_busy(op_busy), .irq(irq));
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One transfer; everything is held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 16) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    apb(0, a, 32'h0, 4'h0);
  endtask
  // Disarm, pick op, arm, unlock, then set start
  task automatic launch(input logic [3:0] o);
    apb(1, CT, 32'h0, 4'h2);
    apb(1, CT, {28'h0, o}, 4'h1);
    apb(1, CT, 32'h4000, 4'h2);
    apb(1, `OFF_KEY, `KEY_FIRST_DEF, 4'hF);
    apb(1, `OFF_KEY, `KEY_SECOND_DEF, 4'hF);
    apb(1, CT, 32'hC000, 4'h2);
  endtask
  // Poll until hardware drops start; bounded so a hang still ends
  task automatic finish_op;
    int n;
    n = 0;
    do begin
      rd(CT);
      n++;
    end while (r[15] && n < 30);
    if (n >= 30) begin
      num_errors++;
      conclude();
    end
  endtask
  function automatic logic [31:0] cx(logic a, f, u, logic [3:0] o);
    return {16'h0, 1'b0, a, f, u, 8'h0, o};
  endfunction
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    rd(CT);
    chk("ctrl reset", r, 32'h0);
    // Random writes while disarmed: op takes, start and flags refuse
    for (int i = 0; i < 8; i++) begin
      d = $random(seed) & 32'hFFFF_BFFF;
      apb(1, CT, d, 4'hF);
      rd(CT);
      chk("ctrl rw", r, cx(0, 0, 0, d[3:0]));
    end
    op = d[3:0];
    // Armed: op frozen; an access between key and start voids unlock
    apb(1, CT, 32'h4000, 4'h2);
    apb(1, CT, {28'h0, ~op}, 4'h1);
    apb(1, CT, 32'hC000, 4'h2);
    apb(1, `OFF_KEY, `KEY_FIRST_DEF, 4'hF);
    apb(1, `OFF_KEY, `KEY_SECOND_DEF, 4'hF);
    rd(CT);
    apb(1, CT, 32'hC000, 4'h2);
    rd(CT);
    chk("ctrl armed", r, cx(1, 0, 0, op));
    apb(1, `OFF_IRQ_MASK, 32'h1, 4'hF);
    launch(4'h3);
    apb(1, CT, 32'h0, 4'hF);
    rd(CT);
    chk("busy ctrl", r, cx(1, 0, 0, 4'h3) | 32'h8000);
    chk("busy pin", {31'h0, op_busy}, 32'h1);
    finish_op;
    chk("op done", r, cx(1, 0, 0, 4'h3));
    chk("idle pin", {31'h0, op_busy}, 32'h0);
    rd(`OFF_IRQ_STAT);
    chk("done stat", r, 32'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    apb(1, `OFF_IRQ_STAT, 32'h1, 4'hF);
    rd(`OFF_IRQ_STAT);
    chk("stat clr", r, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
    // Array fault, then low supply, with the interrupt masked off
    apb(1, `OFF_IRQ_MASK, 32'h0, 4'hF);
    array_fault_pin <= 1;
    launch(4'h1);
    finish_op;
    chk("fail", r, cx(1, 1, 0, 4'h1));
    chk("irq masked", {31'h0, irq}, 32'h0);
    array_fault_pin <= 0;
    low_volt_pin <= 1;
    launch(4'h2);
    finish_op;
    chk("uv", r, cx(1, 1, 1, 4'h2));
    rd(`OFF_FLASH_STAT);
    chk("flash stat", r, 32'h1);
    low_volt_pin <= 0;
    // Bus reset alone must leave the flags standing
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    rd(CT);
    chk("bus reset", r, cx(1, 1, 1, 4'h2));
    launch(`OP_NULL);
    finish_op;
    chk("null op", r, cx(1, 0, 0, 4'h0));
    rd(12'h020);
    chk("unmapped", {31'h0, err}, 32'h1);
    conclude();
  end
endmodule // test_flash_program_control
